// >>> hdl/rx_recovery_pkg.sv
// Purpose: Shared constants and carrier types for the asynchronous receive front end
// Assumes: One system clock, sample tick from an external baud divider
// Notes: Sample numbers count the first low sample as sample one

package rx_recovery_pkg;

   // ---------------------------------------------------------------
   // Sampling geometry
   // ---------------------------------------------------------------
   localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
   localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
   localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
   localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
   localparam logic [3:0] BITS_MIN = 4'h5;
   localparam logic [3:0] BITS_MAX = 4'hA;
   localparam int SYNC_STAGES = 3;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic LINE_IDLE = 1'b1;
   localparam logic [9:0] SHIFT_RESET = 10'h000;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic receiver_enable_bit;
      logic double_speed_select;
      logic [3:0] frame_bits;
   } rx_config_t;

   typedef struct packed {
      logic [9:0] data;
      logic frame_error_flag;
   } rx_frame_t;

endpackage

// >>> hdl/rx_line_sync.sv
// Purpose: Bring the serial line into the clock domain and filter single glitches
// Assumes: Asynchronous input with idle level high
// Notes: Output changes once the last two stages agree

`timescale 1ns/10ps
`default_nettype none

module rx_line_sync
   import rx_recovery_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic line_in,
   output logic line_out
);

   logic [SYNC_STAGES-1:0] stage;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage <= {SYNC_STAGES{LINE_IDLE}};
      end else begin
         stage <= {stage[SYNC_STAGES-2:0], line_in};
      end
   end

   // Stage 0 is read only by stage 1
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         line_out <= LINE_IDLE;
      end else if (stage[1] == stage[2]) begin
         line_out <= stage[2];
      end
   end

   a_sync_agree: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(line_out) |-> $past(stage[1]) == $past(stage[2]) && line_out == $past(stage[2]))
      else $error("line changed before the last two stages agreed");

endmodule

`default_nettype wire

// >>> hdl/rx_vote3.sv
// Purpose: Three-sample majority vote
// Assumes: Samples arrive in order on a qualifier strobe
// Notes: Combinational result on the third sample

`timescale 1ns/10ps
`default_nettype none

module rx_vote3 (
   input wire logic a,
   input wire logic b,
   input wire logic c,
   output logic major
);

   assign major = (a & b) | (a & c) | (b & c);

endmodule

`default_nettype wire

// >>> hdl/uart_async_rx_recovery.sv
// Purpose: Asynchronous receive clock and data recovery for a serial port
// Assumes: sample_tick pulses once per sample period from the baud divider
// Notes: Frame bits count data plus parity, stop bit follows
//
// Overview of operation
// - Sample the line 16 times per bit, or 8 times in double speed.
// - When idle, a high to low transition starts start bit detection.
// - Qualify start with samples 8,9,10 normal or 4,5,6 double speed.
// - Two or more high qualifying samples reject the start as noise.
// - A valid start realigns bit timing; repeated for every frame.
// - Per-bit state counter steps 16 or 8 states, one per sample.
// - Each bit is the majority of its three centre samples.
// - Recover data, parity and first stop bit; ignore further stop bits.
// - Stop bit voted the same way; a zero sets the frame error.
// - Normal mode may detect a new start right after stop voting.
// - Double speed also accepts a new start right after stop voting.
// - Frames carry five to ten data plus parity bits.
// - Each end keeps its rate error within half the total tolerance.
// - Clearing enable abandons the frame at once and releases the pin.

`timescale 1ns/10ps
`default_nettype none

module uart_async_rx_recovery
   import rx_recovery_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample_tick,
   input wire logic serial_rx_pin,
   input wire rx_config_t cfg,
   output logic pin_override,
   output rx_frame_t frame,
   output logic frame_valid,
   output logic start_rejected
);

   typedef enum logic [1:0] {IDLE, START, DATA, STOP} state_t;

   state_t state;
   logic line;
   logic line_prev;
   logic [4:0] sample_no;
   logic [3:0] bit_no;
   logic [1:0] votes;
   logic vote_a;
   logic vote_b;
   logic major;
   logic [9:0] shift;
   logic [4:0] samples_per_bit;
   logic [4:0] vote_first;
   logic [3:0] bits;
   logic in_vote;
   logic last_vote;
   logic fall;

   // ---------------------------------------------------------------
   // Line input
   // ---------------------------------------------------------------
   rx_line_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .line_in(serial_rx_pin),
      .line_out(line)
   );

   rx_vote3 u_vote (
      .a(vote_a),
      .b(vote_b),
      .c(line),
      .major(major)
   );

   // ---------------------------------------------------------------
   // Mode geometry
   // ---------------------------------------------------------------
   assign samples_per_bit = cfg.double_speed_select ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
   // Centre votes plus realignment on every start carry the whole rate error margin
   assign vote_first = cfg.double_speed_select ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
   // Out of range lengths are clamped rather than left undefined
   assign bits = (cfg.frame_bits < BITS_MIN) ? BITS_MIN :
                 (cfg.frame_bits > BITS_MAX) ? BITS_MAX : cfg.frame_bits;
   assign in_vote = sample_tick && (sample_no >= vote_first) && (sample_no <= vote_first + 5'h02);
   assign last_vote = sample_tick && (sample_no == vote_first + 5'h02);
   // Edges judged on ticks only, so glitches between ticks go unseen
   assign fall = sample_tick && line_prev && !line;
   assign pin_override = cfg.receiver_enable_bit;

   // ---------------------------------------------------------------
   // Previous sample for edge detection
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n || !cfg.receiver_enable_bit) begin
         line_prev <= LINE_IDLE;
      end else if (sample_tick) begin
         line_prev <= line;
      end
   end

   // ---------------------------------------------------------------
   // Vote sample capture
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         votes <= 2'h0;
         vote_a <= LINE_IDLE;
         vote_b <= LINE_IDLE;
      end else if (in_vote && state != IDLE) begin
         vote_a <= (votes == 2'h0) ? line : vote_a;
         vote_b <= (votes == 2'h1) ? line : vote_b;
         votes <= (votes == 2'h2) ? 2'h0 : votes + 2'h1;
      end else if (state == IDLE) begin
         votes <= 2'h0;
      end
   end

   // ---------------------------------------------------------------
   // Recovery state machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n || !cfg.receiver_enable_bit) begin
         state <= IDLE;
         sample_no <= 5'h00;
         bit_no <= 4'h0;
         shift <= SHIFT_RESET;
      end else begin
         case (state)
            IDLE: begin
               if (fall) begin
                  state <= START;
                  sample_no <= 5'h02; // Next tick is sample two
               end
            end
            START: begin
               if (sample_tick) begin
                  sample_no <= sample_no + 5'h01;
                  if (last_vote) begin
                     if (major) begin
                        state <= IDLE;
                     end else begin
                        // Realign: next sample is the start bit's following one
                        state <= DATA;
                        bit_no <= 4'h0;
                        shift <= SHIFT_RESET;
                     end
                  end
               end
            end
            DATA: begin
               if (sample_tick) begin
                  // Wrap to sample one at each bit boundary
                  sample_no <= (sample_no == samples_per_bit) ? 5'h01 : sample_no + 5'h01;
                  if (last_vote) begin
                     shift[bit_no] <= major;
                     if (bit_no == bits - 4'h1) begin
                        state <= STOP;
                     end
                     bit_no <= bit_no + 4'h1;
                  end
               end
            end
            STOP: begin
               if (sample_tick) begin
                  sample_no <= (sample_no == samples_per_bit) ? 5'h01 : sample_no + 5'h01;
                  if (last_vote) begin
                     // Further stop bits are not examined
                     state <= IDLE;
                  end
               end
            end
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Results
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frame <= '0;
         frame_valid <= 1'b0;
         start_rejected <= 1'b0;
      end else begin
         frame_valid <= 1'b0;
         start_rejected <= 1'b0;
         // Frame holds until the next completed frame
         if (cfg.receiver_enable_bit && state == STOP && last_vote) begin
            frame.data <= shift;
            frame.frame_error_flag <= !major;
            frame_valid <= 1'b1;
         end
         if (cfg.receiver_enable_bit && state == START && last_vote && major) begin
            start_rejected <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_disable_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg.receiver_enable_bit |=> state == IDLE && !frame_valid)
      else $error("receiver not idle after disable");

   a_stop_error: assert property (@(posedge clk) disable iff (!rst_n)
      frame_valid |-> frame.frame_error_flag == !$past(major))
      else $error("frame error does not follow stop vote");

   a_reject_idle: assert property (@(posedge clk) disable iff (!rst_n)
      start_rejected |-> state == IDLE)
      else $error("rejected start did not return to idle");

   a_start_from_fall: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == START) |-> $past(fall))
      else $error("start entered without falling edge");

   a_sample_bound: assert property (@(posedge clk) disable iff (!rst_n)
      state != IDLE |-> sample_no <= samples_per_bit)
      else $error("sample counter beyond bit length");

   a_bit_bound: assert property (@(posedge clk) disable iff (!rst_n)
      state == DATA |-> bit_no < bits)
      else $error("bit counter beyond frame length");

   a_valid_after_stop: assert property (@(posedge clk) disable iff (!rst_n)
      frame_valid |-> $past(state) == STOP && state == IDLE)
      else $error("frame valid without stop vote");

   a_pin_release: assert property (@(posedge clk) disable iff (!rst_n)
      !pin_override |=> line_prev == LINE_IDLE)
      else $error("line still sampled after pin release");

   // ---------------------------------------------------------------
   // Sequencing checks
   // ---------------------------------------------------------------
   a_fall_starts: assert property (@(posedge clk) disable iff (!rst_n)
      state == IDLE && fall && cfg.receiver_enable_bit |=> state == START)
      else $error("falling edge did not start detection");

   a_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
      state == IDLE && !fall |=> state == IDLE)
      else $error("left idle without a falling edge");

   a_start_sample_two: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == START) |-> sample_no == 5'h02)
      else $error("start count not at sample two");

   a_reject_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      state == START && last_vote && major && cfg.receiver_enable_bit |=> start_rejected && state == IDLE)
      else $error("noisy start not rejected");

   a_reject_from_start: assert property (@(posedge clk) disable iff (!rst_n)
      start_rejected |-> $past(state) == START)
      else $error("reject pulse outside start detection");

   a_accept_realign: assert property (@(posedge clk) disable iff (!rst_n)
      state == START && last_vote && !major && cfg.receiver_enable_bit
      |=> state == DATA && sample_no == vote_first + 5'h03 && bit_no == 4'h0)
      else $error("valid start did not realign bit timing");

   a_bit_wrap: assert property (@(posedge clk) disable iff (!rst_n)
      (state == DATA || state == STOP) && sample_tick && sample_no == samples_per_bit && cfg.receiver_enable_bit
      |=> sample_no == 5'h01)
      else $error("bit counter did not wrap at bit end");

   a_tick_paced: assert property (@(posedge clk) disable iff (!rst_n)
      !sample_tick && cfg.receiver_enable_bit |=> $stable(state) && $stable(sample_no))
      else $error("recovery advanced without a sample tick");

   a_vote_count: assert property (@(posedge clk) disable iff (!rst_n)
      state != IDLE && last_vote && cfg.receiver_enable_bit |=> votes == 2'h0)
      else $error("vote group not three samples");

   a_bit_vote: assert property (@(posedge clk) disable iff (!rst_n)
      state == DATA && last_vote && cfg.receiver_enable_bit |=> shift[$past(bit_no)] == $past(major))
      else $error("voted bit not stored in its place");

   a_lsb_first: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == DATA) |-> bit_no == 4'h0 && shift == SHIFT_RESET)
      else $error("data assembly not starting at bit zero");

   a_data_to_stop: assert property (@(posedge clk) disable iff (!rst_n)
      state == DATA && last_vote && bit_no == bits - 4'h1 && cfg.receiver_enable_bit |=> state == STOP)
      else $error("stop bit not taken after last data bit");

   a_stop_entry: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == STOP) |-> sample_no == vote_first + 5'h03)
      else $error("stop bit timing not carried over");

   a_error_flag: assert property (@(posedge clk) disable iff (!rst_n)
      state == STOP && last_vote && !major && cfg.receiver_enable_bit |=> frame.frame_error_flag)
      else $error("zero stop bit did not flag a frame error");

   a_stop_release: assert property (@(posedge clk) disable iff (!rst_n)
      state == STOP && last_vote && cfg.receiver_enable_bit |=> state == IDLE && frame_valid)
      else $error("not ready for next start after stop vote");

   a_frame_width: assert property (@(posedge clk) disable iff (!rst_n)
      frame_valid |-> (frame.data >> bits) == 10'h000)
      else $error("bits beyond frame length not zero");

endmodule

`default_nettype wire

// >>> test/rx_line_driver_model.sv
// Purpose: Remote transmitter model driving the serial line
// Assumes: Caller enters each task 1 ns after a sample tick
// Notes: Bit lengths are counted in sample ticks

`timescale 1ns/10ps
`default_nettype none

module rx_line_driver_model (
   input wire logic clk,
   input wire logic sample_tick,
   output logic line
);
   // ---------------------------------------------------------------
   // Line timing
   // ---------------------------------------------------------------
   initial line = 1'b1;

   // Exact rate on this end, so the whole mismatch budget stays with the receiver
   task automatic hold(input logic v, input int k);
      line = v;
      repeat (k) @(posedge clk iff sample_tick);
      #1;
   endtask

   // Ends on the stop level; caller idles the line or starts the next frame
   task automatic send(input logic [9:0] d, input int n, input logic stop, input int sl, input int spb);
      hold(1'b0, spb);
      for (int i = 0; i < n; i++) hold(d[i], spb);
      hold(stop, sl);
   endtask
endmodule

`default_nettype wire

// >>> test/uart_async_rx_recovery_tb_top.sv
// Purpose: Self-checking bench for the receive recovery block
// Assumes: Sample tick every eight clocks, inputs moved 1 ns after the edge
// Notes: Completed frames are queued as they arrive

`timescale 1ns/10ps
`default_nettype none

module uart_async_rx_recovery_tb_top import rx_recovery_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sample_tick = 1'b0;
   logic [2:0] tcnt = 3'h0;
   logic line;
   rx_config_t cfg = '0;
   logic pin_override;
   logic frame_valid;
   logic start_rejected;
   rx_frame_t frame;
   rx_frame_t got_q[$];
   int rejects = 0;
   int mismatches = 0;
   int samples_checked = 0;

   always #4 clk = ~clk;
   always @(posedge clk) begin
      #1;
      tcnt = tcnt + 3'h1;
      sample_tick = (tcnt == 3'h0);
   end

   rx_line_driver_model i_rx_line_driver_model (.clk(clk), .sample_tick(sample_tick), .line(line));
   uart_async_rx_recovery i_uart_async_rx_recovery (.clk(clk), .rst_n(rst_n), .sample_tick(sample_tick),
      .serial_rx_pin(line), .cfg(cfg), .pin_override(pin_override), .frame(frame),
      .frame_valid(frame_valid), .start_rejected(start_rejected));

   always @(posedge clk) begin
      if (frame_valid === 1'b1) got_q.push_back(frame);
      if (start_rejected === 1'b1) rejects++;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tk(input int k);
      repeat (k) @(posedge clk iff sample_tick);
      #1;
   endtask

   task automatic idle(input int k);
      i_rx_line_driver_model.hold(1'b1, k);
   endtask

   task automatic expect_frame(input logic [9:0] d, input int n, input logic stop);
      rx_frame_t f;
      check(16'(got_q.size()), 16'h1);
      f = (got_q.size() > 0) ? got_q.pop_front() : '0;
      check({6'h0, f.data}, {6'h0, d & ((10'h1 << n) - 10'h1)});
      check({15'h0, f.frame_error_flag}, {15'h0, ~stop});
   endtask

   task automatic frame_case(input logic [9:0] d, input int n, input logic stop, input logic ds);
      cfg.double_speed_select = ds;
      cfg.frame_bits = 4'(n);
      i_rx_line_driver_model.send(d, n, stop, ds ? 8 : 16, ds ? 8 : 16);
      idle(2);
      expect_frame(d, n, stop);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_widths();
      for (int ds = 0; ds < 2; ds++)
         for (int n = 5; n <= 10; n++) frame_case(10'h2D6 ^ 10'(n), n, 1'b1, ds[0]);
      // Lengths outside five to ten are clamped to the nearest legal one
      cfg.double_speed_select = 1'b0;
      cfg.frame_bits = 4'h3;
      i_rx_line_driver_model.send(10'h015, 5, 1'b1, 16, 16);
      idle(2);
      expect_frame(10'h015, 5, 1'b1);
      cfg.frame_bits = 4'hF;
      i_rx_line_driver_model.send(10'h2A9, 10, 1'b1, 16, 16);
      idle(2);
      expect_frame(10'h2A9, 10, 1'b1);
   endtask

   task automatic t_ferr();
      frame_case(10'h0A5, 8, 1'b0, 1'b0);
      frame_case(10'h15A, 9, 1'b0, 1'b1);
   endtask

   // Low only through the first vote sample: two of three votes high
   task automatic t_noise();
      int r0;
      for (int ds = 0; ds < 2; ds++) begin
         r0 = rejects;
         cfg.double_speed_select = ds[0];
         i_rx_line_driver_model.hold(1'b0, ds ? 4 : 8);
         idle(24);
         check(16'(rejects - r0), 16'h1);
         check(16'(got_q.size()), 16'h0);
         frame_case(10'h133, 7, 1'b1, ds[0]);
      end
   endtask

   // Stop bit cut right after its vote samples, next start at once
   task automatic t_b2b();
      rx_frame_t f;
      for (int ds = 0; ds < 2; ds++) begin
         cfg.double_speed_select = ds[0];
         cfg.frame_bits = 4'h8;
         i_rx_line_driver_model.send(10'h055, 8, 1'b1, ds ? 6 : 10, ds ? 8 : 16);
         i_rx_line_driver_model.send(10'h0AA, 8, 1'b1, ds ? 8 : 16, ds ? 8 : 16);
         idle(2);
         check(16'(got_q.size()), 16'h2);
         f = (got_q.size() > 0) ? got_q.pop_front() : '0;
         check({6'h0, f.data}, 16'h0055);
         check({15'h0, f.frame_error_flag}, 16'h0);
         expect_frame(10'h0AA, 8, 1'b1);
      end
   endtask

   task automatic t_disable();
      cfg.double_speed_select = 1'b0;
      cfg.frame_bits = 4'hA;
      fork
         i_rx_line_driver_model.send(10'h3C3, 10, 1'b1, 16, 16);
         begin
            tk(40);
            cfg.receiver_enable_bit = 1'b0;
            tk(1);
            check({15'h0, pin_override}, 16'h0);
         end
      join
      idle(20);
      check(16'(got_q.size()), 16'h0);
      cfg.receiver_enable_bit = 1'b1;
      idle(2);
      check({15'h0, pin_override}, 16'h1);
      frame_case(10'h3C3, 10, 1'b1, 1'b0);
   endtask

   task automatic summarize();
      $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      cfg.receiver_enable_bit = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      idle(4);
      check({15'h0, pin_override}, 16'h1);
      t_widths();
      t_ferr();
      t_noise();
      t_b2b();
      t_disable();
      summarize();
   end

   // About three times the expected run length
   initial begin
      #600000;
      mismatches++;
      summarize();
   end
endmodule

`default_nettype wire
